/* File: hw/pic_datapath.sv */
// Packed integer and single-precision conversion datapath with its control/status register.
// Assumes issue logic presents one operation per op_valid pulse; results follow one cycle later.
//
// What this block does
// - Packed int-to-float converts two signed 32-bit integers into two singles.
// - Inexact non-truncating conversions round by the control/status rounding mode.
// - Scalar int-to-float converts one signed 32-bit integer into one single.
// - Packed float-to-int converts two singles to integers using current rounding mode.
// - Truncating float-to-int variants match rounding ones but always truncate.
// - Scalar float-to-int converts one single into one signed 32-bit integer.
// - Packed integer operations use 64-bit register and memory operands.
// - With the wide extension the same operations accept 128-bit operands.
// - Unsigned average of bytes or words: add, add one, shift right one.
// - Word extract copies one selected 16-bit word to a general register.
// - Word insert writes a 16-bit word into a selected word position.
// - Unsigned byte max and min keep the greater or lesser byte.
// - Signed word max and min keep the greater or lesser word.
// - Byte sign mask gathers byte MSBs: 8 bits, or 16 for wide.
// - Unsigned high multiply keeps upper 16 bits of each word product.
// - Sum of absolute byte differences goes into the low destination word, or the low word of each 64-bit half for wide.
// - Word shuffle reorders source words by an 8-bit immediate.
// - Control/status load fills the register from memory; store writes it out.
`timescale 1ns/1ns
`default_nettype none
`include "pic_params.svh"

module pic_datapath #(
	parameter bit WIDE_EN = 1'b1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic op_valid,
	input wire pic_pkg::pic_op_e op_code,
	input wire logic op_wide,
	input wire logic [127:0] src_a,
	input wire logic [127:0] src_b,
	input wire logic [7:0] imm,
	input wire logic [31:0] gpr_in,
	input wire logic [31:0] mem_in,
	output logic res_valid_ff,
	output logic [127:0] res_data_ff,
	output logic [31:0] gpr_out_ff,
	output logic [31:0] fp_csr_ff,
	output logic [31:0] mem_out_ff,
	output logic mem_we_ff
);

	////////////////////////////////////////////////////////////////////////////
	// Conversion lanes

	pic_conv_if cv0 ();
	pic_conv_if cv1 ();

	logic is_trunc;
	logic is_to_float;
	pic_pkg::pic_rmode_t lane_rmode;

	assign is_trunc = (op_code == pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT_TRUNC) ||
		(op_code == pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT_TRUNC);
	assign is_to_float = (op_code == pic_pkg::PIC_OP_PACKED_INT_TO_FLOAT) ||
		(op_code == pic_pkg::PIC_OP_SCALAR_INT_TO_FLOAT);
	assign lane_rmode = is_trunc ? `PIC_RM_ZERO : fp_csr_ff[`PIC_RC_MSB:`PIC_RC_LSB];
	// Scalar int-to-float takes its integer from the general register
	assign cv0.a = (op_code == pic_pkg::PIC_OP_SCALAR_INT_TO_FLOAT) ? gpr_in : src_b[31:0];
	assign cv0.to_float = is_to_float;
	assign cv0.rmode = lane_rmode;
	assign cv1.a = src_b[63:32];
	assign cv1.to_float = is_to_float;
	assign cv1.rmode = lane_rmode;

	pic_fp_conv u_conv0 (
		.cv(cv0)
	);

	pic_fp_conv u_conv1 (
		.cv(cv1)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	logic wide_now;
	logic [127:0] nxt_res_data;
	logic [31:0] nxt_gpr_out;
	logic [31:0] nxt_fp_csr;
	logic [31:0] nxt_mem_out;
	logic nxt_mem_we;
	logic nxt_res_valid;

	assign wide_now = WIDE_EN && op_wide;

	always_comb begin
		logic [127:0] r;
		logic [8:0] s9;
		logic [16:0] s17;
		logic [31:0] p32;
		logic [7:0] d8;
		logic [11:0] sad;
		logic [2:0] sel;
		logic [1:0] ws;
		r = 128'h0;
		s9 = 9'h000;
		s17 = 17'h00000;
		p32 = 32'h0;
		d8 = 8'h00;
		sad = 12'h000;
		sel = wide_now ? imm[2:0] : {1'b0, imm[1:0]};
		ws = 2'h0;
		nxt_res_data = res_data_ff;
		nxt_gpr_out = gpr_out_ff;
		nxt_fp_csr = fp_csr_ff;
		nxt_mem_out = mem_out_ff;
		nxt_mem_we = 1'b0;
		nxt_res_valid = op_valid;
		if (op_valid) begin
			unique case (op_code)
				pic_pkg::PIC_OP_PACKED_INT_TO_FLOAT: begin
					nxt_res_data = {src_a[127:64], cv1.y, cv0.y};
				end
				pic_pkg::PIC_OP_SCALAR_INT_TO_FLOAT: begin
					nxt_res_data = {src_a[127:32], cv0.y};
				end
				pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT, pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT_TRUNC: begin
					nxt_res_data = {64'h0, cv1.y, cv0.y};
				end
				pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT, pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT_TRUNC: begin
					nxt_gpr_out = cv0.y;
				end
				pic_pkg::PIC_OP_AVG_UNSIGNED_BYTES: begin
					for (int i = 0; i < 16; i++) begin
						s9 = {1'b0, src_a[i*8 +: 8]} + {1'b0, src_b[i*8 +: 8]} + 9'h001;
						r[i*8 +: 8] = s9[8:1];
					end
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_AVG_UNSIGNED_WORDS: begin
					for (int i = 0; i < 8; i++) begin
						s17 = {1'b0, src_a[i*16 +: 16]} + {1'b0, src_b[i*16 +: 16]} + 17'h00001;
						r[i*16 +: 16] = s17[16:1];
					end
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_WORD_EXTRACT: begin
					nxt_gpr_out = {16'h0000, src_a[sel*16 +: 16]};
				end
				pic_pkg::PIC_OP_WORD_INSERT: begin
					r = src_a;
					r[sel*16 +: 16] = gpr_in[15:0];
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_MAX_UNSIGNED_BYTES, pic_pkg::PIC_OP_MIN_UNSIGNED_BYTES: begin
					for (int i = 0; i < 16; i++) begin
						if ((src_a[i*8 +: 8] > src_b[i*8 +: 8]) == (op_code == pic_pkg::PIC_OP_MAX_UNSIGNED_BYTES)) begin
							r[i*8 +: 8] = src_a[i*8 +: 8];
						end else begin
							r[i*8 +: 8] = src_b[i*8 +: 8];
						end
					end
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_MAX_SIGNED_WORDS, pic_pkg::PIC_OP_MIN_SIGNED_WORDS: begin
					for (int i = 0; i < 8; i++) begin
						if (($signed(src_a[i*16 +: 16]) > $signed(src_b[i*16 +: 16])) ==
							(op_code == pic_pkg::PIC_OP_MAX_SIGNED_WORDS)) begin
							r[i*16 +: 16] = src_a[i*16 +: 16];
						end else begin
							r[i*16 +: 16] = src_b[i*16 +: 16];
						end
					end
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_BYTE_SIGN_MASK: begin
					nxt_gpr_out = 32'h0;
					for (int i = 0; i < 16; i++) begin
						nxt_gpr_out[i] = src_a[i*8+7] & (wide_now || i < 8);
					end
				end
				pic_pkg::PIC_OP_MUL_HIGH_UNSIGNED_WORDS: begin
					for (int i = 0; i < 8; i++) begin
						p32 = src_a[i*16 +: 16] * src_b[i*16 +: 16];
						r[i*16 +: 16] = p32[31:16];
					end
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_SUM_ABS_DIFF_BYTES: begin
					// Each 64-bit half carries its own total in its low word
					for (int h = 0; h < 2; h++) begin
						sad = 12'h000;
						for (int i = 0; i < 8; i++) begin
							d8 = (src_a[h*64+i*8 +: 8] > src_b[h*64+i*8 +: 8]) ?
								(src_a[h*64+i*8 +: 8] - src_b[h*64+i*8 +: 8]) :
								(src_b[h*64+i*8 +: 8] - src_a[h*64+i*8 +: 8]);
							sad = sad + {4'h0, d8};
						end
						r[h*64 +: 16] = {4'h0, sad};
					end
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_WORD_SHUFFLE: begin
					for (int h = 0; h < 2; h++) begin
						for (int w = 0; w < 4; w++) begin
							ws = imm[w*2 +: 2];
							r[h*64+w*16 +: 16] = src_b[h*64+ws*16 +: 16];
						end
					end
					nxt_res_data = r;
				end
				pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS: begin
					nxt_fp_csr = mem_in;
				end
				pic_pkg::PIC_OP_STORE_FP_CONTROL_STATUS: begin
					nxt_mem_out = fp_csr_ff;
					nxt_mem_we = 1'b1;
				end
			endcase
			// Narrow packed integer operations leave the upper half zero; extract and mask do not write the vector
			if (!wide_now && op_code >= pic_pkg::PIC_OP_AVG_UNSIGNED_BYTES &&
				op_code <= pic_pkg::PIC_OP_WORD_SHUFFLE && op_code != pic_pkg::PIC_OP_WORD_EXTRACT &&
				op_code != pic_pkg::PIC_OP_BYTE_SIGN_MASK) begin
				nxt_res_data[127:64] = 64'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge mclk) begin
		if (reset) begin
			res_valid_ff <= 1'b0;
			res_data_ff <= 128'h0;
			gpr_out_ff <= 32'h0;
			fp_csr_ff <= `PIC_CSR_RESET;
			mem_out_ff <= 32'h0;
			mem_we_ff <= 1'b0;
		end else begin
			res_valid_ff <= nxt_res_valid;
			res_data_ff <= nxt_res_data;
			gpr_out_ff <= nxt_gpr_out;
			fp_csr_ff <= nxt_fp_csr;
			mem_out_ff <= nxt_mem_out;
			mem_we_ff <= nxt_mem_we;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	function automatic logic is_op(input pic_pkg::pic_op_e o);
		return op_valid && op_code == o;
	endfunction

	i2f_one_a: assert property (is_op(pic_pkg::PIC_OP_PACKED_INT_TO_FLOAT) && src_b[31:0] == 32'h1
		|=> res_data_ff[31:0] == 32'h3f80_0000)
		else $error("int one did not convert to single one");

	i2f_round_a: assert property (is_op(pic_pkg::PIC_OP_SCALAR_INT_TO_FLOAT) && gpr_in == 32'h0100_0001
		&& fp_csr_ff[`PIC_RC_MSB:`PIC_RC_LSB] == `PIC_RM_UP |=> res_data_ff[31:0] == 32'h4b80_0001)
		else $error("round up of inexact int to single failed");

	i2f_scalar_a: assert property (is_op(pic_pkg::PIC_OP_SCALAR_INT_TO_FLOAT)
		|=> res_data_ff[127:32] == $past(src_a[127:32]))
		else $error("scalar conversion disturbed upper destination");

	f2i_trunc_a: assert property (is_op(pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT_TRUNC)
		&& src_b[31:0] == 32'hbfe0_0000 |=> gpr_out_ff == 32'hffff_ffff)
		else $error("truncation of -1.75 did not give -1");

	f2i_near_a: assert property (is_op(pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT) && src_b[63:32] == 32'h3fc0_0000
		&& fp_csr_ff[`PIC_RC_MSB:`PIC_RC_LSB] == `PIC_RM_NEAR |=> res_data_ff[63:32] == 32'h2)
		else $error("nearest rounding of 1.5 did not give 2");

	avg_byte_a: assert property (is_op(pic_pkg::PIC_OP_AVG_UNSIGNED_BYTES) |=> res_valid_ff &&
		{1'b0, res_data_ff[7:0]} == 9'(({1'b0, $past(src_a[7:0])} + {1'b0, $past(src_b[7:0])} + 9'h001) >> 1))
		else $error("byte average lane 0 wrong");

	extract_word_a: assert property (is_op(pic_pkg::PIC_OP_WORD_EXTRACT) && !wide_now && imm[1:0] == 2'h3
		|=> gpr_out_ff == {16'h0000, $past(src_a[63:48])})
		else $error("word extract picked wrong word");

	max_ubyte_a: assert property (is_op(pic_pkg::PIC_OP_MAX_UNSIGNED_BYTES)
		|=> res_data_ff[15:8] >= $past(src_a[15:8]) && res_data_ff[15:8] >= $past(src_b[15:8]))
		else $error("unsigned byte max below an operand");

	min_sword_a: assert property (is_op(pic_pkg::PIC_OP_MIN_SIGNED_WORDS)
		|=> $signed(res_data_ff[15:0]) <= $signed($past(src_a[15:0])) &&
		$signed(res_data_ff[15:0]) <= $signed($past(src_b[15:0])))
		else $error("signed word min above an operand");

	sign_mask_a: assert property (is_op(pic_pkg::PIC_OP_BYTE_SIGN_MASK) && !wide_now
		|=> gpr_out_ff[31:8] == 24'h0 && gpr_out_ff[7] == $past(src_a[63]))
		else $error("narrow byte sign mask wrong");

	narrow_upper_a: assert property (is_op(pic_pkg::PIC_OP_MUL_HIGH_UNSIGNED_WORDS) && !wide_now
		|=> res_data_ff[127:64] == 64'h0)
		else $error("narrow operation wrote upper half");

	csr_load_a: assert property (is_op(pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS)
		|=> fp_csr_ff == $past(mem_in))
		else $error("control/status load wrong");

	csr_store_a: assert property (is_op(pic_pkg::PIC_OP_STORE_FP_CONTROL_STATUS)
		|=> mem_we_ff && mem_out_ff == $past(fp_csr_ff))
		else $error("control/status store wrong");

	store_pulse_a: assert property (mem_we_ff |=> !mem_we_ff || $past(op_valid))
		else $error("store strobe held without a request");

	wide_cov: cover property (is_op(pic_pkg::PIC_OP_SUM_ABS_DIFF_BYTES) && wide_now ##1 res_valid_ff);
	trunc_cov: cover property (is_op(pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT_TRUNC) && src_b[31] ##1 res_valid_ff);
	csr_cov: cover property (is_op(pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS) ##1
		is_op(pic_pkg::PIC_OP_PACKED_INT_TO_FLOAT));
	shuffle_cov: cover property (is_op(pic_pkg::PIC_OP_WORD_SHUFFLE) && imm == 8'h1b);

endmodule

`default_nettype wire

/* File: hw/pic_params.svh */
// Constants of the packed integer and conversion datapath.
// Included by the design modules; holds definitions only.
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// Control/status register layout
`define PIC_CSR_RESET 32'h0000_0000
`define PIC_RC_LSB 13
`define PIC_RC_MSB 14

// Rounding mode encodings
`define PIC_RM_NEAR 2'h0
`define PIC_RM_DOWN 2'h1
`define PIC_RM_UP 2'h2
`define PIC_RM_ZERO 2'h3

// Single-precision constants
`define PIC_F_BIAS 8'h7f
`define PIC_F_EXP_SMALL 8'h76
`define PIC_F_EXP_OVER 8'h9e
`define PIC_INT_INDEF 32'h8000_0000
`define PIC_INT_MAXP 33'h0_7fff_ffff
`define PIC_INT_MAXN 33'h0_8000_0000

`endif

/* File: hw/pic_pkg.sv */
// Types of the packed integer and conversion datapath.
// Used by the top module and its testbench through scoped names.
package pic_pkg;

	typedef enum logic [4:0] {
		PIC_OP_PACKED_INT_TO_FLOAT = 5'h00,
		PIC_OP_SCALAR_INT_TO_FLOAT = 5'h01,
		PIC_OP_PACKED_FLOAT_TO_INT = 5'h02,
		PIC_OP_PACKED_FLOAT_TO_INT_TRUNC = 5'h03,
		PIC_OP_SCALAR_FLOAT_TO_INT = 5'h04,
		PIC_OP_SCALAR_FLOAT_TO_INT_TRUNC = 5'h05,
		PIC_OP_AVG_UNSIGNED_BYTES = 5'h06,
		PIC_OP_AVG_UNSIGNED_WORDS = 5'h07,
		PIC_OP_WORD_EXTRACT = 5'h08,
		PIC_OP_WORD_INSERT = 5'h09,
		PIC_OP_MAX_UNSIGNED_BYTES = 5'h0a,
		PIC_OP_MIN_UNSIGNED_BYTES = 5'h0b,
		PIC_OP_MAX_SIGNED_WORDS = 5'h0c,
		PIC_OP_MIN_SIGNED_WORDS = 5'h0d,
		PIC_OP_BYTE_SIGN_MASK = 5'h0e,
		PIC_OP_MUL_HIGH_UNSIGNED_WORDS = 5'h0f,
		PIC_OP_SUM_ABS_DIFF_BYTES = 5'h10,
		PIC_OP_WORD_SHUFFLE = 5'h11,
		PIC_OP_LOAD_FP_CONTROL_STATUS = 5'h12,
		PIC_OP_STORE_FP_CONTROL_STATUS = 5'h13
	} pic_op_e;

	typedef logic [1:0] pic_rmode_t;

endpackage

/* File: hw/pic_conv_if.sv */
// Carrier between the datapath top and one conversion lane.
// Purely combinational; the top drives the request side.
`timescale 1ns/1ns
`default_nettype none

interface pic_conv_if;
	logic [31:0] a;
	logic to_float;
	pic_pkg::pic_rmode_t rmode;
	logic [31:0] y;

	modport req (output a, output to_float, output rmode, input y);
	modport cvt (input a, input to_float, input rmode, output y);
endinterface

`default_nettype wire

/* File: hw/pic_fp_conv.sv */
// One conversion lane: signed 32-bit integer to single and back.
// Combinational; the caller registers the result and picks the rounding mode.
`timescale 1ns/1ns
`default_nettype none
`include "pic_params.svh"

module pic_fp_conv (
	pic_conv_if.cvt cv
);

	function automatic logic round_up(input logic [1:0] rm, input logic sgn, input logic lsb,
		input logic g, input logic s);
		logic r;
		r = 1'b0;
		unique case (rm)
			`PIC_RM_NEAR: r = g & (s | lsb);
			`PIC_RM_DOWN: r = sgn & (g | s);
			`PIC_RM_UP: r = ~sgn & (g | s);
			`PIC_RM_ZERO: r = 1'b0;
		endcase
		return r;
	endfunction

	logic sgn;
	logic [31:0] mag;
	logic [4:0] lead;
	logic [31:0] norm;
	logic inc_f;
	logic [23:0] man_r;
	logic [7:0] exp_f;
	logic [31:0] f_res;
	logic [7:0] e;
	logic over;
	logic [63:0] q;
	logic inc_i;
	logic [32:0] imag;
	logic [31:0] i_res;

	always_comb begin
		sgn = cv.a[31];
		// Integer to single: normalise, then round on guard and sticky
		mag = sgn ? (~cv.a + 32'h1) : cv.a;
		lead = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) begin
				lead = i[4:0];
			end
		end
		norm = mag << (5'h1f - lead);
		inc_f = round_up(cv.rmode, sgn, norm[8], norm[7], |norm[6:0]);
		man_r = {1'b0, norm[30:8]} + {23'h000000, inc_f};
		exp_f = `PIC_F_BIAS + {3'h0, lead} + {7'h00, man_r[23]};
		f_res = (mag == 32'h0) ? 32'h0 : {sgn, exp_f, man_r[22:0]};
		// Single to integer: fixed point with 32 fraction bits
		e = cv.a[30:23];
		over = (e >= `PIC_F_EXP_OVER);
		if (e >= `PIC_F_EXP_SMALL) begin
			q = {40'h0, 1'b1, cv.a[22:0]} << (e - `PIC_F_EXP_SMALL);
		end else begin
			// Below 2^-9 only the sticky bit survives
			q = {63'h0, |cv.a[30:0]};
		end
		inc_i = round_up(cv.rmode, sgn, q[32], q[31], |q[30:0]);
		imag = {1'b0, q[63:32]} + {32'h0, inc_i};
		// Overflow, infinity and NaN all give the integer indefinite value
		if (over || (!sgn && imag > `PIC_INT_MAXP) || (sgn && imag > `PIC_INT_MAXN)) begin
			i_res = `PIC_INT_INDEF;
		end else begin
			i_res = sgn ? (~imag[31:0] + 32'h1) : imag[31:0];
		end
		cv.y = cv.to_float ? f_res : i_res;
	end

endmodule

`default_nettype wire

/* File: verification/pic_issue_model.sv */
// Issue logic model: drives one operation per cycle into the datapath.
// Assumes the caller invokes its tasks just after a rising edge of mclk.
`timescale 1ns/1ns
`default_nettype none

module pic_issue_model (
	output logic op_valid,
	output var pic_pkg::pic_op_e op_code,
	output logic op_wide,
	output logic [127:0] src_a,
	output logic [127:0] src_b,
	output logic [7:0] imm,
	output logic [31:0] gpr_in,
	output logic [31:0] mem_in
);

	initial begin
		op_valid = 1'b0;
		op_code = pic_pkg::PIC_OP_AVG_UNSIGNED_BYTES;
		op_wide = 1'b0;
		src_a = '0;
		src_b = '0;
		imm = 8'h00;
		gpr_in = 32'h0;
		mem_in = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic send(input pic_pkg::pic_op_e o, input logic w, input logic [127:0] a, input logic [127:0] b,
		input logic [7:0] i, input logic [31:0] g, input logic [31:0] m);
		op_valid <= 1'b1;
		op_code <= o;
		op_wide <= w;
		src_a <= a;
		src_b <= b;
		imm <= i;
		gpr_in <= g;
		mem_in <= m;
	endtask

	// Operands are inverted when idle so a stale value is never mistaken for a live one
	task automatic idle();
		op_valid <= 1'b0;
		src_a <= ~src_a;
		src_b <= ~src_b;
		gpr_in <= ~gpr_in;
		mem_in <= ~mem_in;
		imm <= ~imm;
	endtask

endmodule

`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the packed integer and conversion datapath.
// Assumes one-cycle result latency and control/status reset to zero.
`timescale 1ns/1ns
`default_nettype none

module tb;
	typedef struct {pic_pkg::pic_op_e op; logic w; logic [127:0] a, b; logic [7:0] i; logic [31:0] g, m;
		logic [127:0] er; logic [31:0] eg; logic [1:0] k;} pic_row_s;
	localparam logic [127:0] hi_pat = {64'h5555_5555_5555_5555, 64'h0};
	localparam logic [127:0] wv = {64'h8888_7777_6666_5555, 64'h4444_3333_2222_1111};
	localparam logic [127:0] mk = {64'h8000_0000_0000_0000, 64'h8000_ff01_7f80_0080};
	logic mclk, reset, op_valid, op_wide, res_valid_ff, mem_we_ff;
	pic_pkg::pic_op_e op_code;
	logic [127:0] src_a, src_b, res_data_ff;
	logic [7:0] imm;
	logic [31:0] gpr_in, mem_in, gpr_out_ff, fp_csr_ff, mem_out_ff, exp_csr;
	int error_cnt, checks;
	pic_row_s rows[$];

	pic_issue_model i_iss (.op_valid(op_valid), .op_code(op_code), .op_wide(op_wide), .src_a(src_a),
		.src_b(src_b), .imm(imm), .gpr_in(gpr_in), .mem_in(mem_in));
	pic_datapath #(.WIDE_EN(1'b1)) i_dut (.mclk(mclk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
		.op_wide(op_wide), .src_a(src_a), .src_b(src_b), .imm(imm), .gpr_in(gpr_in), .mem_in(mem_in),
		.res_valid_ff(res_valid_ff), .res_data_ff(res_data_ff), .gpr_out_ff(gpr_out_ff), .fp_csr_ff(fp_csr_ff),
		.mem_out_ff(mem_out_ff), .mem_we_ff(mem_we_ff));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [127:0] s, input logic [127:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic add(input pic_pkg::pic_op_e o, input logic w, input logic [127:0] a, input logic [127:0] b,
		input logic [7:0] i, input logic [31:0] g, input logic [31:0] m, input logic [127:0] er,
		input logic [31:0] eg, input logic [1:0] k);
		rows.push_back('{o, w, a, b, i, g, m, er, eg, k});
	endtask

	task automatic check_row(input pic_row_s r);
		chk("res_valid", res_valid_ff, 1'b1);
		if (r.k[0]) chk("res_data", res_data_ff, r.er);
		if (r.k[1]) chk("gpr_out", gpr_out_ff, r.eg);
		if (r.op == pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS) exp_csr = r.m;
		chk("fp_csr", fp_csr_ff, exp_csr);
		chk("mem_we", mem_we_ff, r.op == pic_pkg::PIC_OP_STORE_FP_CONTROL_STATUS);
		if (r.op == pic_pkg::PIC_OP_STORE_FP_CONTROL_STATUS) chk("mem_out", mem_out_ff, exp_csr);
	endtask

	task automatic results();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		#1000000;
		error_cnt++;
		results();
	end

	initial begin
		reset = 1'b1;
		exp_csr = 32'h0;
		add(pic_pkg::PIC_OP_PACKED_INT_TO_FLOAT, 0, 0, 64'hffff_ffff_0000_0001, 0, 0, 0, 64'hbf80_0000_3f80_0000, 0, 1);
		add(pic_pkg::PIC_OP_PACKED_INT_TO_FLOAT, 0, hi_pat, 64'h0100_0001, 0, 0, 0, hi_pat | 128'h4b80_0000, 0, 1);
		add(pic_pkg::PIC_OP_SCALAR_INT_TO_FLOAT, 0, 128'h9_0000_0000, 0, 0, 32'h0100_0001, 0, 128'h9_4b80_0000, 0, 1);
		add(pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT, 0, hi_pat, 64'h3fc0_0000_bfc0_0000, 0, 0, 0, 64'h2_ffff_fffe, 0, 1);
		add(pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT_TRUNC, 0, 0, 64'h3fc0_0000_bfc0_0000, 0, 0, 0, 64'h1_ffff_ffff, 0, 1);
		add(pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT, 0, 0, 32'h4020_0000, 0, 0, 0, 0, 32'h2, 2);
		add(pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT_TRUNC, 0, 0, 32'hbfe0_0000, 0, 0, 0, 0, 32'hffff_ffff, 2);
		add(pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT, 0, 0, 32'h4f00_0000, 0, 0, 0, 0, 32'h8000_0000, 2);
		add(pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS, 0, 0, 0, 0, 0, 32'h2000, 0, 0, 0);
		add(pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT, 0, 0, 64'h3fc0_0000_bfc0_0000, 0, 0, 0, 64'h1_ffff_fffe, 0, 1);
		add(pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS, 0, 0, 0, 0, 0, 32'h4000, 0, 0, 0);
		add(pic_pkg::PIC_OP_SCALAR_INT_TO_FLOAT, 0, 0, 0, 0, 32'h0100_0001, 0, 128'h4b80_0001, 0, 1);
		add(pic_pkg::PIC_OP_PACKED_FLOAT_TO_INT, 0, 0, 64'h3fc0_0000_bfc0_0000, 0, 0, 0, 64'h2_ffff_ffff, 0, 1);
		add(pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT_TRUNC, 0, 0, 32'h4020_0000, 0, 0, 0, 0, 32'h2, 2);
		add(pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS, 0, 0, 0, 0, 0, 32'h6000, 0, 0, 0);
		add(pic_pkg::PIC_OP_SCALAR_FLOAT_TO_INT, 0, 0, 32'hbfc0_0000, 0, 0, 0, 0, 32'hffff_ffff, 2);
		add(pic_pkg::PIC_OP_STORE_FP_CONTROL_STATUS, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		add(pic_pkg::PIC_OP_AVG_UNSIGNED_BYTES, 0, hi_pat | 64'hffff_ffff_0000_0001, 64'hffff_ffff_0000_0002, 0, 0, 0,
			64'hffff_ffff_0000_0002, 0, 1);
		add(pic_pkg::PIC_OP_AVG_UNSIGNED_WORDS, 0, 64'hffff_0001, 64'hffff_0002, 0, 0, 0, 64'hffff_0002, 0, 1);
		add(pic_pkg::PIC_OP_MAX_UNSIGNED_BYTES, 0, 16'h8001, 16'h7f02, 0, 0, 0, 16'h8002, 0, 1);
		add(pic_pkg::PIC_OP_MIN_UNSIGNED_BYTES, 0, 16'h8001, 16'h7f02, 0, 0, 0, 16'h7f01, 0, 1);
		add(pic_pkg::PIC_OP_MAX_SIGNED_WORDS, 0, 32'h8000_0001, 32'h7fff_ffff, 0, 0, 0, 32'h7fff_0001, 0, 1);
		add(pic_pkg::PIC_OP_MIN_SIGNED_WORDS, 0, 32'h8000_0001, 32'h7fff_ffff, 0, 0, 0, 32'h8000_ffff, 0, 1);
		add(pic_pkg::PIC_OP_MUL_HIGH_UNSIGNED_WORDS, 0, 32'hffff_0100, 32'hffff_0100, 0, 0, 0, 32'hfffe_0001, 0, 1);
		add(pic_pkg::PIC_OP_SUM_ABS_DIFF_BYTES, 0, 64'h00ff_0000_0000_0010, 64'hff00_0000_0000_0001, 0, 0, 0,
			16'h020d, 0, 1);
		add(pic_pkg::PIC_OP_SUM_ABS_DIFF_BYTES, 1, 128'hff_0000_0000_0000_0010, 0, 0, 0, 0,
			128'hff_0000_0000_0000_0010, 0, 1);
		add(pic_pkg::PIC_OP_WORD_SHUFFLE, 0, 0, wv, 8'h1b, 0, 0, 64'h1111_2222_3333_4444, 0, 1);
		add(pic_pkg::PIC_OP_WORD_SHUFFLE, 1, 0, wv, 8'h1b, 0, 0, {64'h5555_6666_7777_8888, 64'h1111_2222_3333_4444},
			0, 1);
		add(pic_pkg::PIC_OP_BYTE_SIGN_MASK, 0, mk, 0, 0, 0, 0, {64'h5555_6666_7777_8888, 64'h1111_2222_3333_4444},
			32'h00a5, 3);
		add(pic_pkg::PIC_OP_BYTE_SIGN_MASK, 1, mk, 0, 0, 0, 0, 0, 32'h80a5, 2);
		add(pic_pkg::PIC_OP_WORD_EXTRACT, 0, wv, 0, 8'h07, 0, 0, 0, 32'h4444, 2);
		add(pic_pkg::PIC_OP_AVG_UNSIGNED_BYTES, 0, 0, 0, 0, 0, 0, 0, 32'h4444, 3);
		add(pic_pkg::PIC_OP_WORD_EXTRACT, 1, wv, 0, 8'h05, 0, 0, 0, 32'h6666, 2);
		add(pic_pkg::PIC_OP_WORD_INSERT, 0, 64'h4444_3333_2222_1111, 0, 8'h01, 32'hdead_beef, 0,
			64'h4444_3333_beef_1111, 0, 1);
		add(pic_pkg::PIC_OP_WORD_INSERT, 1, wv, 0, 8'h06, 32'hdead_beef, 0, {64'h8888_beef_6666_5555, wv[63:0]},
			0, 1);
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		// Rows issue back to back, so each result is checked while the next op is already on the inputs
		for (int i = 0; i <= rows.size(); i++) begin
			@(posedge mclk);
			if (i < rows.size())
				i_iss.send(rows[i].op, rows[i].w, rows[i].a, rows[i].b, rows[i].i, rows[i].g, rows[i].m);
			else
				i_iss.idle();
			#1;
			if (i == 0) begin
				chk("reset outs", {res_valid_ff, mem_we_ff, res_data_ff[95:0]}, 0);
				chk("reset regs", {gpr_out_ff, fp_csr_ff, mem_out_ff}, 0);
			end else begin
				check_row(rows[i - 1]);
			end
		end
		@(posedge mclk);
		// Reset in mid-run with an op pending must clear the control/status just loaded
		i_iss.send(pic_pkg::PIC_OP_LOAD_FP_CONTROL_STATUS, 0, 0, 0, 0, 0, 32'h4000);
		#1;
		chk("idle valid", res_valid_ff, 1'b0);
		@(posedge mclk);
		reset <= 1'b1;
		i_iss.send(pic_pkg::PIC_OP_STORE_FP_CONTROL_STATUS, 0, 0, 0, 0, 0, 0);
		#1;
		chk("csr loaded", fp_csr_ff, 32'h4000);
		@(posedge mclk);
		reset <= 1'b0;
		#1;
		chk("mid reset", {res_valid_ff, mem_we_ff, fp_csr_ff, gpr_out_ff, mem_out_ff}, 0);
		// The store held through reset is taken at the first edge after release
		@(posedge mclk);
		i_iss.idle();
		#1;
		chk("post reset store", {res_valid_ff, mem_we_ff, mem_out_ff}, {2'b11, 32'h0});
		results();
	end
endmodule

`default_nettype wire
